// *** design/nac_access_ctrl.sv ***
// network access control register with Avalon-MM slave and receive processor state
`timescale 1ns/10ps
`default_nettype none
module nac_access_ctrl
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0] avsByteEnable,
   output logic [31:0] avsReadData,
   output logic avsWaitRequest,
   input wire logic linkSpeed100,
   input wire logic [11:0] txFifoLevel,
   input wire logic txFrameWhole,
   input wire logic txTransmitting,
   input wire logic carrierSense,
   input wire logic rxFrameStart,
   input wire logic rxFrameEnd,
   input wire nac_pkg::nac_rxinfo_t rxInfo,
   input wire logic rxDescUnavail,
   input wire logic rxDescReady,
   input wire logic pauseEnable,
   input wire logic wakeEnable,
   output logic txRunning,
   output logic txStartOk,
   output logic [10:0] txThresholdBytes,
   output logic txForceCollide,
   output logic backoffPause,
   output logic macLoopback,
   output logic rxRunning,
   output logic rxAccept,
   output logic rxDrop
);
   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   logic [31:0] readData_reg;
   logic waitReq_reg;
   logic macLoop_reg;
   logic rxRunning_reg;
   logic inFrame_reg;
   nac_pkg::nac_rxstate_t rxState_reg;
   nac_pkg::nac_rxstate_t rxState_next;
   nac_pkg::nac_ctrl_t ctrl;
   logic busReq;
   logic busTake;
   logic txIdle;
   logic rxIdle;
   logic frameOpen;
   logic [31:0] laneMask;
   logic [31:0] allowMask;
   logic [31:0] statusWord;

   assign ctrl = nac_pkg::nac_unpack(ctrl_reg);
   assign busReq = avsRead || avsWrite;
   // the request is answered at the edge where waitrequest is seen low
   assign busTake = busReq && !waitReq_reg;
   assign txIdle = !txRunning;
   assign rxIdle = (rxState_reg == nac_pkg::NAC_RX_STOP);
   assign frameOpen = inFrame_reg && !rxFrameEnd;
   assign laneMask = {{8{avsByteEnable[3]}}, {8{avsByteEnable[2]}}, {8{avsByteEnable[1]}},
                      {8{avsByteEnable[0]}}};

   // fields whose processors are busy are held; this guards against a careless driver
   always_comb
   begin
      allowMask = nac_pkg::NAC_MASK_FREE;
      if (txIdle)
         allowMask = allowMask | nac_pkg::NAC_MASK_TXIDLE;
      if (rxIdle)
         allowMask = allowMask | nac_pkg::NAC_MASK_RXIDLE;
      if (txIdle && rxIdle)
         allowMask = allowMask | nac_pkg::NAC_MASK_BOTHIDLE;
   end

   always_comb
   begin
      ctrl_next = ctrl_reg;
      if (busTake && avsWrite && (avsAddress == nac_pkg::NAC_OFS_CTRL))
         ctrl_next = nac_pkg::nac_merge(ctrl_reg, avsWriteData, allowMask & laneMask);
   end

   always_comb
   begin
      statusWord = 32'h0000_0000;
      statusWord[nac_pkg::NAC_STAT_RXST +: 2] = rxState_reg;
      statusWord[nac_pkg::NAC_STAT_TXRUN] = txRunning;
      statusWord[nac_pkg::NAC_STAT_INFRAME] = inFrame_reg;
      statusWord[nac_pkg::NAC_STAT_THR +: 11] = txThresholdBytes;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         ctrl_reg <= nac_pkg::NAC_CTRL_RESET;
      else
         ctrl_reg <= ctrl_next;
   end

   // one wait state: waitrequest drops for the cycle after the request appears
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         waitReq_reg <= 1'b1;
      else if (busReq && waitReq_reg)
         waitReq_reg <= 1'b0;
      else
         waitReq_reg <= 1'b1;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         readData_reg <= 32'h0000_0000;
      else if (avsRead && waitReq_reg)
      begin
         case (avsAddress)
            nac_pkg::NAC_OFS_CTRL: readData_reg <= ctrl_reg;
            nac_pkg::NAC_OFS_STAT: readData_reg <= statusWord;
            default: readData_reg <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         macLoop_reg <= 1'b0;
      else
         macLoop_reg <= (ctrl.operatingSel == nac_pkg::NAC_OPSEL_MACLOOP);
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         inFrame_reg <= 1'b0;
      else if (rxFrameStart)
         inFrame_reg <= 1'b1;
      else if (rxFrameEnd)
         inFrame_reg <= 1'b0;
   end

   always_comb
   begin
      rxState_next = rxState_reg;
      case (rxState_reg)
         nac_pkg::NAC_RX_STOP:
         begin
            if (ctrl.rxRun)
               rxState_next = nac_pkg::NAC_RX_RUN;
         end
         nac_pkg::NAC_RX_RUN:
         begin
            if (!ctrl.rxRun && !frameOpen)
               rxState_next = nac_pkg::NAC_RX_STOP;
            else if (ctrl.rxRun && rxDescUnavail)
               rxState_next = nac_pkg::NAC_RX_SUSP;
         end
         nac_pkg::NAC_RX_SUSP:
         begin
            if (!ctrl.rxRun && !frameOpen)
               rxState_next = nac_pkg::NAC_RX_STOP;
            else if (ctrl.rxRun && rxDescReady)
               rxState_next = nac_pkg::NAC_RX_RUN;
         end
         default: rxState_next = nac_pkg::NAC_RX_STOP;
      endcase
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rxState_reg <= nac_pkg::NAC_RX_STOP;
         rxRunning_reg <= 1'b0;
      end
      else
      begin
         rxState_reg <= rxState_next;
         rxRunning_reg <= (rxState_next == nac_pkg::NAC_RX_RUN);
      end
   end

   nac_tx_ctrl u_tx
   (
      .clk(clk),
      .resetn(resetn),
      .ctrl(ctrl),
      .linkSpeed100(linkSpeed100),
      .txFifoLevel(txFifoLevel),
      .txFrameWhole(txFrameWhole),
      .txTransmitting(txTransmitting),
      .carrierSense(carrierSense),
      .txRunning(txRunning),
      .txStartOk(txStartOk),
      .txThresholdBytes(txThresholdBytes),
      .txForceCollide(txForceCollide),
      .backoffPause(backoffPause)
   );

   nac_rx_filter u_rxf
   (
      .clk(clk),
      .resetn(resetn),
      .ctrl(ctrl),
      .rxStopped(rxIdle),
      .rxFrameEnd(rxFrameEnd),
      .rxInfo(rxInfo),
      .pauseEnable(pauseEnable),
      .wakeEnable(wakeEnable),
      .rxAccept(rxAccept),
      .rxDrop(rxDrop)
   );

   assign avsReadData = readData_reg;
   assign avsWaitRequest = waitReq_reg;
   assign macLoopback = macLoop_reg;
   assign rxRunning = rxRunning_reg;
endmodule : nac_access_ctrl
`default_nettype wire

// *** design/nac_rx_filter.sv ***
// receive accept/discard decision, registered as one-cycle pulses at frame end
`timescale 1ns/10ps
`default_nettype none
module nac_rx_filter
(
   input wire logic clk,
   input wire logic resetn,
   input wire nac_pkg::nac_ctrl_t ctrl,
   input wire logic rxStopped,
   input wire logic rxFrameEnd,
   input wire nac_pkg::nac_rxinfo_t rxInfo,
   input wire logic pauseEnable,
   input wire logic wakeEnable,
   output logic rxAccept,
   output logic rxDrop
);
   logic addrPass;
   logic qualityPass;
   logic specialPass;
   logic takeIt;

   always_comb
   begin
      addrPass = ctrl.acceptAllFrames || rxInfo.destMatch
                 || (ctrl.allMulticast && rxInfo.multicast);
      // accept-all with bad pass lets every bad frame through while receive is not stopped
      qualityPass = !rxInfo.badFrame || ctrl.passBadFrames;
      specialPass = (rxInfo.pauseFrame && pauseEnable) || (rxInfo.wakeFrame && wakeEnable);
      takeIt = specialPass || (!rxStopped && addrPass && qualityPass);
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rxAccept <= 1'b0;
         rxDrop <= 1'b0;
      end
      else
      begin
         rxAccept <= rxFrameEnd && takeIt;
         rxDrop <= rxFrameEnd && !takeIt;
      end
   end
endmodule : nac_rx_filter
`default_nettype wire

// *** design/nac_tx_ctrl.sv ***
// transmit-side steering: threshold, start decision, collision forcing, back-off hold
`timescale 1ns/10ps
`default_nettype none
module nac_tx_ctrl
(
   input wire logic clk,
   input wire logic resetn,
   input wire nac_pkg::nac_ctrl_t ctrl,
   input wire logic linkSpeed100,
   input wire logic [11:0] txFifoLevel,
   input wire logic txFrameWhole,
   input wire logic txTransmitting,
   input wire logic carrierSense,
   output logic txRunning,
   output logic txStartOk,
   output logic [10:0] txThresholdBytes,
   output logic txForceCollide,
   output logic backoffPause
);
   logic [10:0] thrNow;

   // speed is read live, so a renegotiated link moves the threshold at once
   assign thrNow = nac_pkg::nac_thresh_bytes(ctrl.txThresholdSel, linkSpeed100);

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         txRunning <= 1'b0;
         txThresholdBytes <= nac_pkg::NAC_THR10_0;
      end
      else
      begin
         txRunning <= ctrl.txRun;
         txThresholdBytes <= thrNow;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         txStartOk <= 1'b0;
      else if (!ctrl.txRun)
         txStartOk <= 1'b0;
      else if (ctrl.storeForward)
         txStartOk <= txFrameWhole;
      else
         txStartOk <= txFrameWhole || (txFifoLevel >= {1'b0, thrNow});
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         txForceCollide <= 1'b0;
         backoffPause <= 1'b0;
      end
      else
      begin
         txForceCollide <= ctrl.forceCollision && txTransmitting;
         backoffPause <= ctrl.carrierBackoffHold && carrierSense;
      end
   end
endmodule : nac_tx_ctrl
`default_nettype wire

// *** shared/nac_pkg.sv ***
// constants, types and helpers for the network access control block
package nac_pkg;
   localparam logic [7:0] NAC_OFS_CTRL = 8'h30;
   localparam logic [7:0] NAC_OFS_STAT = 8'h80;

   localparam int NAC_BIT_STOREFWD = 21;
   localparam int NAC_BIT_THRSEL = 14;
   localparam int NAC_BIT_TXRUN = 13;
   localparam int NAC_BIT_FORCECOL = 12;
   localparam int NAC_BIT_OPSEL = 10;
   localparam int NAC_BIT_ALLMCAST = 7;
   localparam int NAC_BIT_ACCALL = 6;
   localparam int NAC_BIT_BOHOLD = 5;
   localparam int NAC_BIT_PASSBAD = 3;
   localparam int NAC_BIT_RXRUN = 1;

   localparam logic [31:0] NAC_CTRL_RESET = 32'h0000_0040;
   // write masks grouped by the processors that must be idle
   localparam logic [31:0] NAC_MASK_TXIDLE = 32'h0020_c000;
   localparam logic [31:0] NAC_MASK_BOTHIDLE = 32'h0000_1c60;
   localparam logic [31:0] NAC_MASK_RXIDLE = 32'h0000_0088;
   localparam logic [31:0] NAC_MASK_FREE = 32'h0000_2002;

   localparam int NAC_STAT_RXST = 0;
   localparam int NAC_STAT_TXRUN = 2;
   localparam int NAC_STAT_INFRAME = 3;
   localparam int NAC_STAT_THR = 16;

   localparam logic [1:0] NAC_OPSEL_NORMAL = 2'h0;
   localparam logic [1:0] NAC_OPSEL_MACLOOP = 2'h1;

   localparam logic [10:0] NAC_THR100_0 = 11'h080;
   localparam logic [10:0] NAC_THR100_1 = 11'h100;
   localparam logic [10:0] NAC_THR100_2 = 11'h200;
   localparam logic [10:0] NAC_THR100_3 = 11'h400;
   localparam logic [10:0] NAC_THR10_0 = 11'h048;
   localparam logic [10:0] NAC_THR10_1 = 11'h060;
   localparam logic [10:0] NAC_THR10_2 = 11'h080;
   localparam logic [10:0] NAC_THR10_3 = 11'h0a0;

   typedef struct packed {
      logic storeForward;
      logic [1:0] txThresholdSel;
      logic txRun;
      logic forceCollision;
      logic [1:0] operatingSel;
      logic allMulticast;
      logic acceptAllFrames;
      logic carrierBackoffHold;
      logic passBadFrames;
      logic rxRun;
   } nac_ctrl_t;

   typedef struct packed {
      logic destMatch;
      logic multicast;
      logic badFrame;
      logic pauseFrame;
      logic wakeFrame;
   } nac_rxinfo_t;

   typedef enum logic [1:0] {NAC_RX_STOP, NAC_RX_RUN, NAC_RX_SUSP} nac_rxstate_t;

   function automatic nac_ctrl_t nac_unpack(input logic [31:0] r);
      nac_ctrl_t c;
      c.storeForward = r[NAC_BIT_STOREFWD];
      c.txThresholdSel = r[NAC_BIT_THRSEL +: 2];
      c.txRun = r[NAC_BIT_TXRUN];
      c.forceCollision = r[NAC_BIT_FORCECOL];
      c.operatingSel = r[NAC_BIT_OPSEL +: 2];
      c.allMulticast = r[NAC_BIT_ALLMCAST];
      c.acceptAllFrames = r[NAC_BIT_ACCALL];
      c.carrierBackoffHold = r[NAC_BIT_BOHOLD];
      c.passBadFrames = r[NAC_BIT_PASSBAD];
      c.rxRun = r[NAC_BIT_RXRUN];
      return c;
   endfunction : nac_unpack

   function automatic logic [10:0] nac_thresh_bytes(input logic [1:0] code, input logic fast);
      logic [10:0] b;
      b = NAC_THR10_0;
      case ({fast, code})
         3'h0: b = NAC_THR10_0;
         3'h1: b = NAC_THR10_1;
         3'h2: b = NAC_THR10_2;
         3'h3: b = NAC_THR10_3;
         3'h4: b = NAC_THR100_0;
         3'h5: b = NAC_THR100_1;
         3'h6: b = NAC_THR100_2;
         3'h7: b = NAC_THR100_3;
         default: b = NAC_THR10_0;
      endcase
      return b;
   endfunction : nac_thresh_bytes

   function automatic logic [31:0] nac_merge(input logic [31:0] cur, input logic [31:0] wd,
                                             input logic [31:0] m);
      return (cur & ~m) | (wd & m);
   endfunction : nac_merge
endpackage : nac_pkg

// *** verification/nac_access_ctrl_properties.sv ***
// port-level assertions for the network access control register block
`timescale 1ns/10ps
`default_nettype none
module nac_access_ctrl_properties
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsReadData,
   input wire logic avsWaitRequest,
   input wire logic linkSpeed100,
   input wire logic txTransmitting,
   input wire logic carrierSense,
   input wire logic rxFrameEnd,
   input wire logic [10:0] txThresholdBytes,
   input wire logic txForceCollide,
   input wire logic backoffPause,
   input wire logic rxAccept,
   input wire logic rxDrop
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   wire rdAck = avsRead && !avsWaitRequest;
   a_wait_answer: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
      else $error("request not answered");
   a_wait_single: assert property (!avsWaitRequest |=> avsWaitRequest)
      else $error("wait low too long");
   a_unmapped_zero: assert property (rdAck && avsAddress != nac_pkg::NAC_OFS_CTRL
      && avsAddress != nac_pkg::NAC_OFS_STAT |-> avsReadData == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_reserved_zero: assert property (rdAck && avsAddress == nac_pkg::NAC_OFS_CTRL
      |-> (avsReadData & ~32'h0020_fcea) == 32'h0000_0000)
      else $error("reserved bit set");
   a_collide_cause: assert property (txForceCollide |-> $past(txTransmitting))
      else $error("collision without transmit");
   a_backoff_cause: assert property (backoffPause |-> $past(carrierSense))
      else $error("pause without carrier");
   a_one_verdict: assert property (rxFrameEnd |=> rxAccept != rxDrop)
      else $error("no single verdict");
   a_verdict_cause: assert property (rxAccept || rxDrop |-> $past(rxFrameEnd))
      else $error("verdict without frame end");
   a_thr_fast: assert property (linkSpeed100 && $stable(linkSpeed100)
      |=> txThresholdBytes inside {11'h080, 11'h100, 11'h200, 11'h400})
      else $error("fast threshold wrong");
   a_thr_slow: assert property (!linkSpeed100 && $stable(linkSpeed100)
      |=> txThresholdBytes inside {11'h048, 11'h060, 11'h080, 11'h0a0})
      else $error("slow threshold wrong");
   cover property (rxAccept);
   cover property (txForceCollide);
   cover property (backoffPause);
endmodule : nac_access_ctrl_properties
bind nac_access_ctrl nac_access_ctrl_properties u_chk
(
   .clk(clk),
   .resetn(resetn),
   .avsAddress(avsAddress),
   .avsRead(avsRead),
   .avsWrite(avsWrite),
   .avsReadData(avsReadData),
   .avsWaitRequest(avsWaitRequest),
   .linkSpeed100(linkSpeed100),
   .txTransmitting(txTransmitting),
   .carrierSense(carrierSense),
   .rxFrameEnd(rxFrameEnd),
   .txThresholdBytes(txThresholdBytes),
   .txForceCollide(txForceCollide),
   .backoffPause(backoffPause),
   .rxAccept(rxAccept),
   .rxDrop(rxDrop)
);
`default_nettype wire

// *** verification/tb_nac_access_ctrl.sv ***
// self-checking bench for the network access control register block
`timescale 1ns/10ps
`default_nettype none
module tb_nac_access_ctrl;
   logic clk, resetn = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, linkSpeed100 = 1'b0;
   logic txFrameWhole = 1'b0, txTransmitting = 1'b0, carrierSense = 1'b0, rxFrameStart = 1'b0;
   logic rxFrameEnd = 1'b0, rxDescUnavail = 1'b0, rxDescReady = 1'b0, pauseEnable = 1'b0, wakeEnable = 1'b1;
   logic avsWaitRequest, txRunning, txStartOk, txForceCollide, backoffPause, macLoopback, rxRunning;
   logic rxAccept, rxDrop;
   logic [7:0] avsAddress = 8'h0;
   logic [31:0] avsWriteData = 32'h0, avsReadData, rd;
   logic [3:0] avsByteEnable = 4'hf;
   logic [3:0] busBe = 4'hf;
   logic [11:0] txFifoLevel = 12'h0;
   logic [10:0] txThresholdBytes;
   nac_pkg::nac_rxinfo_t rxInfo = '0;
   int failCount = 0, comparisons = 0;
   logic [10:0] thr [8] = '{11'h048, 11'h060, 11'h080, 11'h0a0, 11'h080, 11'h100, 11'h200, 11'h400};
   nac_access_ctrl u_nac_access_ctrl
   (
      .clk(clk),
      .resetn(resetn),
      .avsAddress(avsAddress),
      .avsRead(avsRead),
      .avsWrite(avsWrite),
      .avsWriteData(avsWriteData),
      .avsByteEnable(avsByteEnable),
      .avsReadData(avsReadData),
      .avsWaitRequest(avsWaitRequest),
      .linkSpeed100(linkSpeed100),
      .txFifoLevel(txFifoLevel),
      .txFrameWhole(txFrameWhole),
      .txTransmitting(txTransmitting),
      .carrierSense(carrierSense),
      .rxFrameStart(rxFrameStart),
      .rxFrameEnd(rxFrameEnd),
      .rxInfo(rxInfo),
      .rxDescUnavail(rxDescUnavail),
      .rxDescReady(rxDescReady),
      .pauseEnable(pauseEnable),
      .wakeEnable(wakeEnable),
      .txRunning(txRunning),
      .txStartOk(txStartOk),
      .txThresholdBytes(txThresholdBytes),
      .txForceCollide(txForceCollide),
      .backoffPause(backoffPause),
      .macLoopback(macLoopback),
      .rxRunning(rxRunning),
      .rxAccept(rxAccept),
      .rxDrop(rxDrop)
   );
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic stopTest;
      if (failCount == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stopTest
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         failCount++;
         $display("ERROR %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avsAddress <= a;
      avsWriteData <= d;
      avsByteEnable <= busBe;
      avsWrite <= wr;
      avsRead <= !wr;
      // request stands until waitrequest is seen low at a rising edge
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avsWaitRequest !== 1'b0 && n < 20);
      if (avsWaitRequest !== 1'b0)
      begin
         failCount++;
         $display("ERROR %0t: bus hang", $time);
         stopTest();
      end
      else
      begin
         rd = avsReadData;
         avsWrite <= 1'b0;
         avsRead <= 1'b0;
      end
   endtask : bus
   task automatic waitc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : waitc
   // pulse frame end with its info and judge the verdict a cycle later
   task automatic frame(input logic [4:0] info, input logic acc);
      @(posedge clk);
      rxFrameEnd <= 1'b1;
      rxInfo <= nac_pkg::nac_rxinfo_t'(info);
      @(posedge clk);
      rxFrameEnd <= 1'b0;
      #1;
      chk(rxAccept, acc);
      chk(rxDrop, !acc);
   endtask : frame
   // one-cycle descriptor event: ready resumes, otherwise unavailable suspends
   task automatic descPulse(input logic rdy);
      @(posedge clk);
      rxDescUnavail <= !rdy;
      rxDescReady <= rdy;
      @(posedge clk);
      rxDescUnavail <= 1'b0;
      rxDescReady <= 1'b0;
      #1;
   endtask : descPulse
   task automatic testRegs;
      bus(1'b0, 8'h30, 32'h0);
      chk(rd, 32'h0000_0040);
      bus(1'b1, 8'h30, 32'hffff_dffd);
      bus(1'b0, 8'h30, 32'h0);
      chk(rd, 32'h0020_dce8);
      chk(macLoopback, 1'b0);
      bus(1'b1, 8'h44, 32'hffff_ffff);
      bus(1'b0, 8'h44, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, 8'h80, 32'h0);
      chk(rd, 32'h00a0_0000);
      busBe = 4'h1;
      bus(1'b1, 8'h30, 32'h0);
      busBe = 4'hf;
      bus(1'b0, 8'h30, 32'h0);
      chk(rd, 32'h0020_dc00);
      for (int i = 0; i < 8; i++)
      begin
         bus(1'b1, 8'h30, {16'h0, i[1:0], 2'h0, i[1:0], 2'h0, 8'h40});
         linkSpeed100 <= i[2];
         waitc(2);
         chk(macLoopback, i[1:0] == 2'h1);
         chk(txThresholdBytes, thr[i]);
      end
   endtask : testRegs
   task automatic testTx;
      bus(1'b1, 8'h30, 32'h0020_0040);
      bus(1'b1, 8'h30, 32'h0020_2040);
      txFifoLevel <= 12'h400;
      waitc(3);
      chk(txRunning, 1'b1);
      chk(txStartOk, 1'b0);
      @(posedge clk);
      txFrameWhole <= 1'b1;
      waitc(3);
      chk(txStartOk, 1'b1);
      // store-forward cannot be cleared while transmit runs
      bus(1'b1, 8'h30, 32'h0000_2040);
      bus(1'b0, 8'h30, 32'h0);
      chk(rd, 32'h0020_2040);
      bus(1'b1, 8'h30, 32'h0000_0040);
      bus(1'b1, 8'h30, 32'h0000_2040);
      txFrameWhole <= 1'b0;
      txFifoLevel <= 12'h07f;
      waitc(3);
      chk(txStartOk, 1'b0);
      @(posedge clk);
      txFifoLevel <= 12'h080;
      waitc(3);
      chk(txStartOk, 1'b1);
      bus(1'b1, 8'h30, 32'h0000_0040);
   endtask : testTx
   task automatic testCollide;
      bus(1'b1, 8'h30, 32'h0000_1060);
      txTransmitting <= 1'b1;
      carrierSense <= 1'b1;
      waitc(3);
      chk(txForceCollide, 1'b1);
      chk(backoffPause, 1'b1);
      bus(1'b1, 8'h30, 32'h0000_0040);
      txTransmitting <= 1'b0;
      waitc(2);
      chk(txForceCollide, 1'b0);
      chk(backoffPause, 1'b0);
      @(posedge clk);
      carrierSense <= 1'b0;
   endtask : testCollide
   task automatic testRx;
      frame(5'h10, 1'b0);
      frame(5'h02, 1'b0);
      frame(5'h01, 1'b1);
      @(posedge clk);
      pauseEnable <= 1'b1;
      frame(5'h02, 1'b1);
      bus(1'b1, 8'h30, 32'h0000_0042);
      waitc(1);
      chk(rxRunning, 1'b1);
      frame(5'h00, 1'b1);
      frame(5'h04, 1'b0);
      @(posedge clk);
      rxFrameStart <= 1'b1;
      @(posedge clk);
      rxFrameStart <= 1'b0;
      bus(1'b1, 8'h30, 32'h0000_0048);
      waitc(1);
      chk(rxRunning, 1'b1);
      frame(5'h10, 1'b1);
      waitc(1);
      chk(rxRunning, 1'b0);
      bus(1'b1, 8'h30, 32'h0000_0048);
      bus(1'b1, 8'h30, 32'h0000_004a);
      frame(5'h04, 1'b1);
      bus(1'b1, 8'h30, 32'h0000_0048);
      bus(1'b1, 8'h30, 32'h0000_0088);
      bus(1'b1, 8'h30, 32'h0000_008a);
      frame(5'h08, 1'b1);
      frame(5'h00, 1'b0);
      frame(5'h10, 1'b1);
      descPulse(1'b0);
      chk(rxRunning, 1'b0);
      bus(1'b0, 8'h80, 32'h0);
      chk(rd, 32'h0080_0002);
      descPulse(1'b1);
      chk(rxRunning, 1'b1);
      descPulse(1'b0);
      bus(1'b1, 8'h30, 32'h0000_0088);
      bus(1'b0, 8'h80, 32'h0);
      chk(rd, 32'h0080_0000);
   endtask : testRx
   initial
   begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      testRegs();
      testTx();
      testCollide();
      testRx();
      stopTest();
   end
endmodule : tb_nac_access_ctrl
`default_nettype wire
